// file: core/ahp_pkg.sv
`default_nettype none
package ahp_pkg;
    // bus clock and the two line bit rates
    localparam int CLK_HZ = 125_000_000;
    localparam int FAST_BPS = 100_000;
    localparam int SLOW_BPS = 12_500;
    // half-bit periods in clock cycles
    localparam int HALF_FAST = CLK_HZ / (2 * FAST_BPS);
    localparam int HALF_SLOW = CLK_HZ / (2 * SLOW_BPS);
    // silence of this many half bits resynchronises a receiver
    localparam int GAP_HALVES = 3;
    // null bits sent between transmitted words
    localparam int GAP_BITS = 4;
    localparam int RX_N = 4;
    localparam int TX_N = 4;
    localparam int WORD = 32;
    localparam int DEPTH = 32;
    localparam int AW = 5;
    localparam int LEVEL = 16;
    localparam int LEG_W = 16;
    // register index in haddr[3:2]
    localparam logic [1:0] REG_DATA = 2'h0;
    localparam logic [1:0] REG_CTRL = 2'h1;
    localparam logic [1:0] REG_STAT = 2'h2;
    localparam int DIR_BIT = 4;
    localparam int CH_LSB = 5;
    localparam logic [8:0] CFG_ADDR = 9'h1E0;
    localparam int CFG_LEGACY = 0;
    localparam int CTRL_RATE = 0;
    localparam int CTRL_LOOP = 1;
    localparam int STAT_EMPTY = 0;
    localparam int STAT_LEVEL = 1;
    localparam int STAT_FULL = 2;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // pin bundle width and its idle value (strobes high)
    localparam int PIN_W = 33;
    localparam logic [32:0] PIN_RST = 33'h0DE000000;
    typedef enum logic {ST_IDLE = 1'b0, ST_WAIT = 1'b1} ahp_phase_type;
endpackage
`default_nettype wire

// file: core/ahp_fifo_if.sv
`default_nettype none
interface ahp_fifo_if;
    logic push;
    logic [ahp_pkg::WORD-1:0] wdata;
    logic pop;
    logic [ahp_pkg::WORD-1:0] rdata;
    logic full;
    logic empty;
    logic level;
    modport store (input push, wdata, pop, output rdata, full, empty, level);
    modport user (output push, wdata, pop, input rdata, full, empty, level);
endinterface
`default_nettype wire

// file: core/ahp_fifo.sv
`default_nettype none
module ahp_fifo (
    input wire logic hclk,
    input wire logic hresetn,
    ahp_fifo_if.store q
);
    logic [ahp_pkg::WORD-1:0] mem [ahp_pkg::DEPTH];
    logic [ahp_pkg::AW:0] wr_ptr;
    logic [ahp_pkg::AW:0] rd_ptr;
    wire [ahp_pkg::AW:0] used = wr_ptr - rd_ptr;
    // a push into a full queue is dropped, not wrapped
    wire do_push = q.push && !q.full;
    wire do_pop = q.pop && !q.empty;

    // pointer update
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (ahp_pkg::AW + 1)'(do_push);
            rd_ptr <= rd_ptr + (ahp_pkg::AW + 1)'(do_pop);
        end
    end

    // storage, no reset needed
    always_ff @(posedge hclk) begin
        if (do_push) begin
            mem[wr_ptr[ahp_pkg::AW-1:0]] <= q.wdata;
        end
    end

    // show-ahead head word and flags
    assign q.rdata = mem[rd_ptr[ahp_pkg::AW-1:0]];
    assign q.full = used == (ahp_pkg::AW + 1)'(ahp_pkg::DEPTH);
    assign q.empty = used == '0;
    assign q.level = used >= (ahp_pkg::AW + 1)'(ahp_pkg::LEVEL);

    a_level_nonempty: assert property (@(posedge hclk) disable iff (!hresetn)
        q.level |-> !q.empty && used >= 6'h10) else $error("level flag without words");
    a_full_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        q.full && !q.pop |=> q.full) else $error("full flag dropped without pop");
endmodule
`default_nettype wire

// file: core/ahp_top.sv
`default_nettype none
module ahp_top #(
    parameter int SLOW_HALF_CYC = ahp_pkg::HALF_SLOW
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [8:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [ahp_pkg::TX_N-1:0] txa,
    output logic [ahp_pkg::TX_N-1:0] txb,
    input wire logic [ahp_pkg::RX_N-1:0] rxa,
    input wire logic [ahp_pkg::RX_N-1:0] rxb,
    output logic [ahp_pkg::RX_N-1:0] int_out_rx,
    output logic [ahp_pkg::TX_N-1:0] int_out_tx,
    output logic [ahp_pkg::RX_N-1:0] rx_fifo_full,
    output logic [ahp_pkg::RX_N-1:0] rx_fifo_half_full,
    output logic [ahp_pkg::RX_N-1:0] rx_fifo_empty,
    output logic [ahp_pkg::TX_N-1:0] tx_fifo_full,
    output logic [ahp_pkg::TX_N-1:0] tx_fifo_half_full,
    output logic [ahp_pkg::TX_N-1:0] tx_fifo_empty,
    output logic int_out,
    output logic legacy_rcv1_not_empty,
    output logic legacy_rcv1_queue_full,
    output logic legacy_rcv1_queue_half,
    output logic legacy_rcv2_not_empty,
    output logic legacy_rcv2_queue_full,
    output logic legacy_rcv2_queue_half,
    output logic transmit_fifo_full,
    output logic transmit_half_full,
    output logic tx_ready,
    input wire logic rsel,
    input wire logic control_load_n,
    input wire logic status_read_n,
    input wire logic tx_enable,
    input wire logic first_half_latch_n,
    input wire logic second_half_latch_n,
    input wire logic rcv1_bus_drive_n,
    input wire logic rcv2_bus_drive_n,
    input wire logic test_mode,
    input wire logic [ahp_pkg::LEG_W-1:0] legacy_bus_in,
    output logic [ahp_pkg::LEG_W-1:0] legacy_bus_out,
    output logic legacy_bus_oe_n,
    output logic data_valid
);
    localparam int receive_channel_count = ahp_pkg::RX_N;
    localparam int transmit_channel_count = ahp_pkg::TX_N;

    // pins pass two flops; stage one feeds stage two only
    logic [ahp_pkg::PIN_W-1:0] pin_m;
    logic [ahp_pkg::PIN_W-1:0] pin_s;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_m <= ahp_pkg::PIN_RST;
            pin_s <= ahp_pkg::PIN_RST;
        end else begin
            pin_m <= {rsel, control_load_n, status_read_n, tx_enable, first_half_latch_n,
                second_half_latch_n, rcv1_bus_drive_n, rcv2_bus_drive_n, test_mode, rxa, rxb,
                legacy_bus_in};
            pin_s <= pin_m;
        end
    end
    logic s_rsel, s_ctl_n, s_str_n, s_entx, s_fh_n, s_sh_n, s_d1_n, s_d2_n, s_test;
    logic [receive_channel_count-1:0] s_rxa;
    logic [receive_channel_count-1:0] s_rxb;
    logic [ahp_pkg::LEG_W-1:0] s_bus;
    assign {s_rsel, s_ctl_n, s_str_n, s_entx, s_fh_n, s_sh_n, s_d1_n, s_d2_n, s_test,
        s_rxa, s_rxb, s_bus} = pin_s;

    // previous strobe levels for edge detection
    logic p_ctl_n, p_fh_n, p_sh_n, p_d1_n, p_d2_n;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {p_ctl_n, p_fh_n, p_sh_n, p_d1_n, p_d2_n} <= 5'h1F;
        end else begin
            {p_ctl_n, p_fh_n, p_sh_n, p_d1_n, p_d2_n} <= {s_ctl_n, s_fh_n, s_sh_n,
                s_d1_n, s_d2_n};
        end
    end

    // bus slave: one address phase, one wait cycle, then done
    ahp_pkg::ahp_phase_type phase;
    ahp_pkg::ahp_phase_type next_phase;
    logic [8:0] a_addr;
    logic a_write;
    wire take = hsel && hready && htrans[1] && phase == ahp_pkg::ST_IDLE;
    always_comb begin
        unique case (phase)
            ahp_pkg::ST_IDLE: next_phase = take ? ahp_pkg::ST_WAIT : ahp_pkg::ST_IDLE;
            ahp_pkg::ST_WAIT: next_phase = ahp_pkg::ST_IDLE;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= ahp_pkg::ST_IDLE;
            a_addr <= 9'h000;
            a_write <= 1'b0;
        end else begin
            phase <= next_phase;
            if (take) begin
                a_addr <= haddr;
                a_write <= hwrite;
            end
        end
    end
    // the wait cycle gives the queue head time to settle
    assign hreadyout = phase == ahp_pkg::ST_IDLE;
    assign hresp = 1'b0;

    // address decode of the captured transfer
    wire in_data = phase == ahp_pkg::ST_WAIT;
    wire [1:0] a_ch = a_addr[ahp_pkg::CH_LSB +: 2];
    wire ch_ok = a_addr[8:7] == 2'h0;
    wire a_tx = a_addr[ahp_pkg::DIR_BIT];
    wire [1:0] a_reg = a_addr[3:2];
    wire a_cfg = a_addr == ahp_pkg::CFG_ADDR;
    wire wr_go = in_data && a_write;
    wire rd_go = in_data && !a_write;
    wire wr_tx_data = wr_go && ch_ok && a_tx && a_reg == ahp_pkg::REG_DATA;
    wire rd_rx_data = rd_go && ch_ok && !a_tx && a_reg == ahp_pkg::REG_DATA;
    wire wr_ctrl = wr_go && ch_ok && a_reg == ahp_pkg::REG_CTRL;

    logic cfg_legacy;
    logic [7:0] rx_ctrl [receive_channel_count];
    logic [7:0] tx_ctrl [transmit_channel_count];
    logic [2:0] rx_stat [receive_channel_count];
    logic [2:0] tx_stat [transmit_channel_count];
    logic [31:0] rx_head [receive_channel_count];
    logic [transmit_channel_count-1:0] tx_busy;
    logic [transmit_channel_count-1:0] tx_push;
    logic [receive_channel_count-1:0] leg_pop;
    logic leg_push;
    logic [15:0] leg_low;

    // read selection; tx data is write only and reads zero
    wire [7:0] sel_ctrl = a_tx ? tx_ctrl[a_ch] : rx_ctrl[a_ch];
    wire [2:0] sel_stat = a_tx ? tx_stat[a_ch] : rx_stat[a_ch];
    wire [31:0] sel_data = a_tx ? 32'h00000000 : rx_head[a_ch];
    wire [31:0] rd_word = a_cfg ? {31'h00000000, cfg_legacy} :
        !ch_ok ? 32'h00000000 :
        a_reg == ahp_pkg::REG_DATA ? sel_data :
        a_reg == ahp_pkg::REG_CTRL ? {24'h000000, sel_ctrl} :
        a_reg == ahp_pkg::REG_STAT ? {29'h00000000, sel_stat} : 32'h00000000;

    // read data and mode register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            cfg_legacy <= 1'b0;
        end else begin
            if (rd_go) begin
                hrdata <= rd_word;
            end
            if (wr_go && a_cfg) begin
                cfg_legacy <= hwdata[ahp_pkg::CFG_LEGACY];
            end
        end
    end

    // half-bit tick dividers for the two rates
    logic [12:0] fcnt;
    logic [12:0] scnt;
    wire tick_fast = fcnt == 13'(ahp_pkg::HALF_FAST - 1);
    wire tick_slow = scnt == 13'(SLOW_HALF_CYC - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fcnt <= 13'h0000;
            scnt <= 13'h0000;
        end else begin
            fcnt <= tick_fast ? 13'h0000 : fcnt + 13'h0001;
            scnt <= tick_slow ? 13'h0000 : scnt + 13'h0001;
        end
    end

    ahp_fifo_if rx_q [receive_channel_count] ();
    ahp_fifo_if tx_q [transmit_channel_count] ();

    // transmit channels
    for (genvar i = 0; i < transmit_channel_count; i++) begin : g_tx
        logic busy, ph, line_a, line_b;
        logic [5:0] cnt;
        logic [31:0] sh;
        wire tick = tx_ctrl[i][ahp_pkg::CTRL_RATE] ? tick_slow : tick_fast;
        wire leg0 = cfg_legacy && i == 0;
        wire start = !busy && !tx_q[i].empty && (!leg0 || s_entx);
        wire bit_on = busy && !ph && cnt < 6'(ahp_pkg::WORD);
        wire mute = leg0 && s_test;
        assign tx_push[i] = (wr_tx_data && a_ch == 2'(i)) || (leg0 && leg_push);
        assign tx_q[i].push = tx_push[i];
        assign tx_q[i].wdata = (leg0 && leg_push) ? {s_bus, leg_low} : hwdata;
        assign tx_q[i].pop = start;
        ahp_fifo u_fifo (
            .hclk(hclk),
            .hresetn(hresetn),
            .q(tx_q[i])
        );
        // shifter: lsb first, return to zero, then a null gap
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                busy <= 1'b0;
                ph <= 1'b0;
                cnt <= 6'h00;
                sh <= 32'h00000000;
                tx_ctrl[i] <= ahp_pkg::CTRL_RST;
            end else begin
                if (wr_ctrl && a_tx && a_ch == 2'(i)) begin
                    tx_ctrl[i] <= hwdata[7:0];
                end
                if (start) begin
                    busy <= 1'b1;
                    ph <= 1'b0;
                    cnt <= 6'h00;
                    sh <= tx_q[i].rdata;
                end else if (busy && tick) begin
                    ph <= !ph;
                    if (ph) begin
                        sh <= sh >> 1;
                        cnt <= cnt + 6'h01;
                        busy <= cnt != 6'(ahp_pkg::WORD + ahp_pkg::GAP_BITS - 1);
                    end
                end
            end
        end
        // line drive from flops; both low is null
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                line_a <= 1'b0;
                line_b <= 1'b0;
            end else begin
                line_a <= bit_on && sh[0] && !mute;
                line_b <= bit_on && !sh[0] && !mute;
            end
        end
        assign txa[i] = line_a;
        assign txb[i] = line_b;
        assign tx_busy[i] = busy;
        assign tx_fifo_full[i] = tx_q[i].full;
        assign tx_fifo_empty[i] = tx_q[i].empty;
        assign tx_fifo_half_full[i] = tx_q[i].level;
        assign tx_stat[i][ahp_pkg::STAT_EMPTY] = tx_q[i].empty;
        assign tx_stat[i][ahp_pkg::STAT_LEVEL] = tx_q[i].level;
        assign tx_stat[i][ahp_pkg::STAT_FULL] = tx_q[i].full;
        assign int_out_tx[i] = tx_q[i].empty || tx_q[i].full || tx_q[i].level;
    end

    // receive channels; loopback takes the paired transmitter's lines
    for (genvar i = 0; i < receive_channel_count; i++) begin : g_rx
        logic pa, pb;
        logic [4:0] cnt;
        logic [31:0] sh;
        logic [14:0] idle;
        wire loop = tx_ctrl[i][ahp_pkg::CTRL_LOOP];
        wire la = loop ? txa[i] : s_rxa[i];
        wire lb = loop ? txb[i] : s_rxb[i];
        wire seen = (la || lb) && !(pa || pb);
        wire [14:0] lim = rx_ctrl[i][ahp_pkg::CTRL_RATE] ?
            15'(ahp_pkg::GAP_HALVES * SLOW_HALF_CYC) :
            15'(ahp_pkg::GAP_HALVES * ahp_pkg::HALF_FAST);
        assign rx_q[i].push = seen && cnt == 5'h1F;
        assign rx_q[i].wdata = {la, sh[31:1]};
        assign rx_q[i].pop = (rd_rx_data && a_ch == 2'(i)) || leg_pop[i];
        ahp_fifo u_fifo (
            .hclk(hclk),
            .hresetn(hresetn),
            .q(rx_q[i])
        );
        // bit capture on each null-to-mark transition
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pa <= 1'b0;
                pb <= 1'b0;
                cnt <= 5'h00;
                sh <= 32'h00000000;
                idle <= 15'h0000;
                rx_ctrl[i] <= ahp_pkg::CTRL_RST;
            end else begin
                if (wr_ctrl && !a_tx && a_ch == 2'(i)) begin
                    rx_ctrl[i] <= hwdata[7:0];
                end
                pa <= la;
                pb <= lb;
                idle <= (la || lb) ? 15'h0000 : (&idle ? idle : idle + 15'h0001);
                if (seen) begin
                    sh <= {la, sh[31:1]};
                    cnt <= cnt + 5'h01;
                end else if (idle >= lim) begin
                    cnt <= 5'h00; // long silence drops a partial word
                end
            end
        end
        assign rx_head[i] = rx_q[i].rdata;
        assign rx_fifo_full[i] = rx_q[i].full;
        assign rx_fifo_empty[i] = rx_q[i].empty;
        assign rx_fifo_half_full[i] = rx_q[i].level;
        assign rx_stat[i][ahp_pkg::STAT_EMPTY] = rx_q[i].empty;
        assign rx_stat[i][ahp_pkg::STAT_LEVEL] = rx_q[i].level;
        assign rx_stat[i][ahp_pkg::STAT_FULL] = rx_q[i].full;
        assign int_out_rx[i] = rx_q[i].empty || rx_q[i].full || rx_q[i].level;
    end

    assign int_out = |int_out_rx || |int_out_tx;

    // legacy flag pins on receivers 0, 1 and transmitter 0
    assign legacy_rcv1_not_empty = !rx_fifo_empty[0];
    assign legacy_rcv2_not_empty = !rx_fifo_empty[1];
    assign legacy_rcv1_queue_full = rx_fifo_full[0];
    assign legacy_rcv1_queue_half = rx_fifo_half_full[0];
    assign legacy_rcv2_queue_full = rx_fifo_full[1];
    assign legacy_rcv2_queue_half = rx_fifo_half_full[1];
    assign transmit_fifo_full = tx_fifo_full[0];
    assign transmit_half_full = tx_fifo_half_full[0];

    // legacy strobe decode
    logic leg_half_pend;
    logic [7:0] leg_ctrl;
    wire leg_ctl_rise = cfg_legacy && s_ctl_n && !p_ctl_n;
    wire leg_pl1 = cfg_legacy && !s_fh_n && p_fh_n;
    wire leg_pl2 = cfg_legacy && !s_sh_n && p_sh_n;
    assign leg_push = leg_pl2 && leg_half_pend;
    wire rd_stat = cfg_legacy && !s_str_n;
    wire drv1 = cfg_legacy && !s_d1_n;
    wire drv2 = cfg_legacy && !s_d2_n && s_d1_n;
    wire leg_drive = rd_stat || drv1 || drv2;
    // a word leaves its queue when the upper-half read ends
    assign leg_pop[0] = cfg_legacy && s_d1_n && !p_d1_n && s_rsel;
    assign leg_pop[1] = cfg_legacy && s_d2_n && !p_d2_n && s_d1_n && s_rsel;
    assign leg_pop[receive_channel_count-1:2] = '0;
    wire [15:0] half0 = s_rsel ? rx_head[0][31:16] : rx_head[0][15:0];
    wire [15:0] half1 = s_rsel ? rx_head[1][31:16] : rx_head[1][15:0];
    wire [7:0] leg_stat = {2'h0, !rx_fifo_empty[1], !rx_fifo_empty[0], tx_ready,
        tx_fifo_full[0], tx_fifo_half_full[0], tx_fifo_empty[0]};
    wire [7:0] reg_pick = s_rsel ? leg_ctrl : leg_stat;
    wire [15:0] next_bus = rd_stat ? {8'h00, reg_pick} : drv1 ? half0 : drv2 ? half1 : 16'h0000;
    wire next_valid = rd_stat || (drv1 && !rx_fifo_empty[0]) || (drv2 && !rx_fifo_empty[1]);

    // legacy bus drive from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            legacy_bus_out <= 16'h0000;
            legacy_bus_oe_n <= 1'b1;
            data_valid <= 1'b0;
        end else begin
            legacy_bus_out <= next_bus;
            legacy_bus_oe_n <= !leg_drive;
            data_valid <= next_valid;
        end
    end

    // legacy registers; a push beats the idle condition on ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            leg_ctrl <= ahp_pkg::CTRL_RST;
            leg_low <= 16'h0000;
            leg_half_pend <= 1'b0;
            tx_ready <= 1'b1;
        end else begin
            if (leg_ctl_rise) begin
                leg_ctrl <= s_bus[7:0];
            end
            if (leg_pl1) begin
                leg_low <= s_bus;
                leg_half_pend <= 1'b1;
            end else if (leg_push) begin
                leg_half_pend <= 1'b0;
            end
            if (tx_push[0]) begin
                tx_ready <= 1'b0;
            end else if (tx_fifo_empty[0] && !tx_busy[0]) begin
                tx_ready <= 1'b1;
            end
        end
    end

    default clocking ck @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_wait_state: assert property (take |=> !hreadyout ##1 hreadyout)
        else $error("access did not take exactly one wait cycle");
    a_cfg_read: assert property (take && !hwrite && haddr == ahp_pkg::CFG_ADDR
        |-> ##2 hrdata == {31'h00000000, $past(cfg_legacy, 2)})
        else $error("mode register read back wrong");
    a_int_any: assert property (int_out == |{rx_fifo_empty, rx_fifo_full,
        rx_fifo_half_full, tx_fifo_empty, tx_fifo_full, tx_fifo_half_full})
        else $error("combined interrupt mismatch");
    a_txr_loaded: assert property (leg_push |=> !tx_ready)
        else $error("ready stayed high after load");
    a_txr_idle: assert property (tx_ready |-> !tx_busy[0])
        else $error("ready high while sending");
    a_test_mute: assert property (cfg_legacy && s_test |=> !txa[0] && !txb[0])
        else $error("line driven in test");
    a_bus_float: assert property (!leg_drive |=> legacy_bus_oe_n)
        else $error("bus driven with no reader");
    a_rcv1_first: assert property (drv1 && !rd_stat |=> legacy_bus_out == $past(half0))
        else $error("receiver 1 data not on bus");
    a_status_pick: assert property (rd_stat && !s_rsel
        |=> legacy_bus_out[7:0] == $past(leg_stat)) else $error("status byte wrong");
    a_ctrl_load: assert property (leg_ctl_rise |=> leg_ctrl == $past(s_bus[7:0]))
        else $error("control byte not loaded");
    a_entx_gate: assert property (cfg_legacy && !s_entx && !tx_busy[0]
        |=> !tx_busy[0]) else $error("send started while disabled");
    c_bus_write: cover property (take && hwrite ##2 hreadyout);
    c_leg_load: cover property (leg_push);
    c_tx_start: cover property ($rose(tx_busy[0]));
endmodule
`default_nettype wire

// file: verification/ahp_host.sv
`default_nettype none
module ahp_host (
    input wire logic hclk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [8:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic rd_done,
    output logic [31:0] rd_val
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {hsel, haddr, htrans, hwrite, hsize, hwdata, rd_done, rd_val} = '0;
    // single word transfer; each phase held until ready is seen high
    task automatic xfer(input logic wr, input logic [8:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2; // whole words only
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_val <= hrdata;
        rd_done <= !wr;
        @(posedge hclk);
        rd_done <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: verification/test_arinc_multichannel_host_port.sv
`default_nettype none
module test_arinc_multichannel_host_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [8:0] lg = 9'h0FE;
    logic hsel, hwrite, hreadyout, rd_done, tx_ready, int_out, oe_n, data_valid, ne1;
    logic [2:0] hsize;
    logic [3:0] rx_a = 4'h0;
    logic [3:0] rx_b = 4'h0;
    logic [15:0] lbus = 16'h0000;
    logic [15:0] lout;
    logic [1:0] htrans;
    logic [8:0] haddr;
    logic [31:0] hwdata, hrdata, rd_val;
    logic [3:0] tx_full, tx_half, tx_empty, int_tx;
    logic [31:0] expq[$];
    int fail_count = 0;
    int comparisons = 0;
    ahp_host host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .rd_done(rd_done), .rd_val(rd_val));
    // short half bit so a looped word crosses in about 1500 cycles
    ahp_top #(.SLOW_HALF_CYC(20)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .txa(), .txb(),
        .rxa(rx_a), .rxb(rx_b), .int_out_rx(), .int_out_tx(int_tx), .rx_fifo_full(),
        .rx_fifo_half_full(), .rx_fifo_empty(), .tx_fifo_full(tx_full),
        .tx_fifo_half_full(tx_half), .tx_fifo_empty(tx_empty), .int_out(int_out),
        .legacy_rcv1_not_empty(ne1), .legacy_rcv1_queue_full(), .legacy_rcv1_queue_half(),
        .legacy_rcv2_not_empty(), .legacy_rcv2_queue_full(), .legacy_rcv2_queue_half(),
        .transmit_fifo_full(), .transmit_half_full(), .tx_ready(tx_ready), .rsel(lg[0]),
        .control_load_n(lg[1]), .status_read_n(lg[2]), .tx_enable(lg[3]),
        .first_half_latch_n(lg[4]), .second_half_latch_n(lg[5]), .rcv1_bus_drive_n(lg[6]),
        .rcv2_bus_drive_n(lg[7]), .test_mode(lg[8]), .legacy_bus_in(lbus),
        .legacy_bus_out(lout), .legacy_bus_oe_n(oe_n), .data_valid(data_valid));
    initial forever #4 hclk = ~hclk;
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // oldest expected read value against each completed read
    always @(posedge hclk) begin
        if (rd_done) chk(expq.pop_front() === rd_val, "read data");
    end
    // hang guard, well past the longest wait
    initial begin
        repeat (10000) @(posedge hclk);
        fail_count++;
        end_of_test();
    end
    initial begin
        logic [31:0] w;
        void'($urandom(32'hEF0FC1BB));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(tx_ready === 1'b1 && int_out === 1'b1 && tx_empty === 4'hF, "reset");
        // channel 0 looped back at slow rate
        host.xfer(1'b1, 9'h014, 32'h00000003);
        w = $urandom;
        host.xfer(1'b1, 9'h010, w);
        @(posedge hclk);
        chk(tx_ready === 1'b0, "ready after load");
        repeat (3000) if (tx_ready !== 1'b1) @(posedge hclk);
        chk(tx_ready === 1'b1, "ready after send");
        repeat (8) @(posedge hclk);
        expq.push_back(w);
        host.xfer(1'b0, 9'h000, 32'h0);
        expq.push_back(32'h0);
        host.xfer(1'b0, 9'h00C, 32'h0);
        // fill channel 1 at fast rate, at most one word leaves meanwhile
        for (int i = 1; i <= 33; i++) begin
            host.xfer(1'b1, 9'h030, $urandom);
            if (i == 15) chk(tx_half[1] === 1'b0, "below level");
            if (i == 17) chk(tx_half[1] === 1'b1, "at level");
        end
        chk(tx_full[1] === 1'b1 && int_tx[1] === 1'b1, "full");
        expq.push_back(32'h6);
        host.xfer(1'b0, 9'h038, 32'h0);
        // random word on receiver 2 pins, one mark then null per bit
        w = $urandom;
        for (int b = 0; b < 32; b++) begin
            rx_a[2] <= w[b];
            rx_b[2] <= !w[b];
            repeat (4) @(posedge hclk);
            {rx_a[2], rx_b[2]} <= 2'h0;
            repeat (4) @(posedge hclk);
        end
        repeat (8) @(posedge hclk);
        expq.push_back(w);
        host.xfer(1'b0, 9'h040, 32'h0);
        // legacy mode on, read back
        host.xfer(1'b1, 9'h1E0, 32'h1);
        expq.push_back(32'h1);
        host.xfer(1'b0, 9'h1E0, 32'h0);
        // control byte taken on the strobe's rising edge
        w = $urandom;
        lbus <= w[15:0];
        lg[1] <= 1'b0;
        repeat (4) @(posedge hclk);
        lg[1] <= 1'b1;
        repeat (4) @(posedge hclk);
        // legacy status read drives the bus only while strobed
        lg[2] <= 1'b0;
        repeat (6) @(posedge hclk);
        chk(oe_n === 1'b0 && data_valid === 1'b1 && lout === 16'h0009, "status read");
        lg[0] <= 1'b1;
        repeat (5) @(posedge hclk);
        chk(lout === {8'h00, w[7:0]}, "control read");
        lg[2] <= 1'b1;
        lg[0] <= 1'b0;
        repeat (6) @(posedge hclk);
        chk(oe_n === 1'b1 && data_valid === 1'b0, "bus released");
        // two halves loaded while sending is held off, then looped back
        w = $urandom;
        lg[3] <= 1'b0;
        lbus <= w[15:0];
        lg[4] <= 1'b0;
        repeat (4) @(posedge hclk);
        lbus <= w[31:16];
        lg[4] <= 1'b1;
        lg[5] <= 1'b0;
        repeat (5) @(posedge hclk);
        lg[5] <= 1'b1;
        chk(tx_ready === 1'b0 && tx_empty[0] === 1'b0, "held load");
        lg[3] <= 1'b1;
        repeat (3000) if (tx_ready !== 1'b1) @(posedge hclk);
        // receiver 1 read half by half; release on the high half pops
        lg[6] <= 1'b0;
        repeat (5) @(posedge hclk);
        chk(ne1 === 1'b1 && data_valid === 1'b1 && lout === w[15:0], "low half");
        lg[0] <= 1'b1;
        repeat (5) @(posedge hclk);
        chk(lout === w[31:16], "high half");
        lg[6] <= 1'b1;
        repeat (5) @(posedge hclk);
        chk(ne1 === 1'b0, "popped");
        hresetn <= 1'b0;
        #2 chk(tx_full[1] === 1'b0 && tx_empty === 4'hF, "async reset");
        end_of_test();
    end
endmodule
`default_nettype wire
